// *** verilog/fwc_codec.v ***
/*
 filter wheel command decoder and status reply encoder.
 assumes command bytes arrive synchronous to clk with valid/ready and that
 reply bytes are drained through a 16 word fifo by the host link.
*/
`include "fwc_codec_regs.vh"
`default_nettype none

module fwc_codec #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire clk,
	input wire reset_n,
	input wire [7:0] cmd_data,
	input wire cmd_valid,
	output wire cmd_ready,
	output wire [7:0] reply_data,
	output wire reply_valid,
	input wire reply_ready,
	input wire shutter_c_enable,
	input wire [1:0] shutter_a_state,
	input wire [1:0] shutter_b_state,
	output reg move_valid,
	output reg [1:0] move_wheel,
	output reg [2:0] move_speed,
	output reg [3:0] move_pos,
	output reg shutter_c_open,
	output reg config_start,
	output reg motion_reset
);
	// =====================================================
	// states
	// nine states, so the code needs four bits
	localparam ST_IDLE = 4'h0;
	localparam ST_PREFIX = 4'h1;
	localparam ST_ECHO = 4'h2;
	localparam ST_WA = 4'h3;
	localparam ST_WB = 4'h4;
	localparam ST_CIND = 4'h5;
	localparam ST_WC = 4'h6;
	localparam ST_SHA = 4'h7;
	localparam ST_SHB = 4'h8;

	reg [3:0] st_reg;
	reg [3:0] st_next;
	reg [7:0] wa_reg;
	reg [7:0] wb_reg;
	reg [7:0] wc_reg;
	reg [7:0] rep_byte;
	reg rep_push;
	wire fifo_in_ready;
	wire take;
	wire is_move;
	wire pos_ok;
	wire [7:0] b;

	// =====================================================
	// byte intake
	// status bytes are pushed one per cycle; intake stalls while replying
	assign b = cmd_data;
	assign cmd_ready = (st_reg == ST_IDLE[3:0]) || (st_reg == ST_PREFIX[3:0]);
	assign take = cmd_valid && cmd_ready;
	// a move byte has position 0..9 and is not a special code
	assign pos_ok = (b[`FWC_POS_HI:`FWC_POS_LO] <= `FWC_POS_MAX);
	assign is_move = pos_ok;

	// =====================================================
	// reply byte selection
	always @* begin
		rep_byte = 8'h00;
		rep_push = 1'b0;
		case (st_reg)
		ST_ECHO: begin
			rep_byte = `FWC_CODE_STATUS;
			rep_push = 1'b1;
		end
		ST_WA: begin
			rep_byte = {1'b0, wa_reg[6:0]};
			rep_push = 1'b1;
		end
		ST_WB: begin
			rep_byte = {1'b1, wb_reg[6:0]};
			rep_push = 1'b1;
		end
		ST_CIND: begin
			rep_byte = `FWC_CODE_PREFIX_C;
			rep_push = 1'b1;
		end
		ST_WC: begin
			rep_byte = {1'b0, wc_reg[6:0]};
			rep_push = 1'b1;
		end
		ST_SHA: begin
			rep_push = 1'b1;
			case (shutter_a_state)
			`FWC_SH_OPEN: rep_byte = `FWC_SHA_OPEN;
			`FWC_SH_COND: rep_byte = `FWC_SHA_COND;
			default: rep_byte = `FWC_SHA_CLOSED;
			endcase
		end
		ST_SHB: begin
			rep_push = 1'b1;
			case (shutter_b_state)
			`FWC_SH_OPEN: rep_byte = `FWC_SHB_OPEN;
			`FWC_SH_COND: rep_byte = `FWC_SHB_COND;
			default: rep_byte = `FWC_SHB_CLOSED;
			endcase
		end
		default: begin
			rep_byte = 8'h00;
			rep_push = 1'b0;
		end
		endcase
	end

	// =====================================================
	// next state
	always @* begin
		st_next = st_reg;
		case (st_reg)
		ST_IDLE: begin
			if (take) begin
				if (b == `FWC_CODE_STATUS)
					st_next = ST_ECHO[3:0];
				else if (b == `FWC_CODE_PREFIX_C)
					st_next = ST_PREFIX[3:0];
			end
		end
		ST_PREFIX: begin
			// anything but a good move byte drops the prefix
			if (take)
				st_next = ST_IDLE[3:0];
		end
		ST_ECHO, ST_WA, ST_CIND, ST_SHA: begin
			if (fifo_in_ready)
				st_next = st_reg + 4'h1;
		end
		ST_WB: begin
			// shutter c replaces the third wheel, so its bytes are skipped
			if (fifo_in_ready)
				st_next = shutter_c_enable ? ST_SHA[3:0] : ST_CIND[3:0];
		end
		ST_WC: begin
			if (fifo_in_ready)
				st_next = ST_SHA[3:0];
		end
		ST_SHB: begin
			if (fifo_in_ready)
				st_next = ST_IDLE[3:0];
		end
		default: st_next = ST_IDLE[3:0];
		endcase
	end

	// =====================================================
	// state and command outputs
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= 4'h0;
			wa_reg <= `FWC_STATE_RESET;
			wb_reg <= `FWC_STATE_RESET;
			wc_reg <= `FWC_STATE_RESET;
			move_valid <= 1'b0;
			move_wheel <= 2'h0;
			move_speed <= 3'h0;
			move_pos <= 4'h0;
			shutter_c_open <= 1'b0;
			config_start <= 1'b0;
			motion_reset <= 1'b0;
		end else begin
			st_reg <= st_next;
			move_valid <= 1'b0;
			config_start <= 1'b0;
			motion_reset <= 1'b0;
			if (take && b == `FWC_CODE_RESET) begin
				st_reg <= 4'h0;
				motion_reset <= 1'b1;
			end else if (take && st_reg == ST_IDLE[3:0] &&
				b == `FWC_CODE_CONFIG) begin
				config_start <= 1'b1;
			end else if (take && st_reg == ST_IDLE[3:0] &&
				b == `FWC_CODE_SHC_OPEN) begin
				if (shutter_c_enable)
					shutter_c_open <= 1'b1;
			end else if (take && st_reg == ST_IDLE[3:0] &&
				b == `FWC_CODE_SHC_CLOSE) begin
				if (shutter_c_enable)
					shutter_c_open <= 1'b0;
			end else if (take && b == `FWC_CODE_SHC_COND) begin
				// defined but inert
				shutter_c_open <= shutter_c_open;
			end else if (take && st_reg == ST_PREFIX[3:0]) begin
				if (is_move && !b[`FWC_WHEEL_BIT]) begin
					wc_reg <= b;
					move_valid <= 1'b1;
					move_wheel <= 2'h2;
					move_speed <= b[`FWC_SPEED_HI:`FWC_SPEED_LO];
					move_pos <= b[`FWC_POS_HI:`FWC_POS_LO];
				end
			end else if (take && st_reg == ST_IDLE[3:0] && is_move &&
				b != `FWC_CODE_STATUS) begin
				move_valid <= 1'b1;
				move_speed <= b[`FWC_SPEED_HI:`FWC_SPEED_LO];
				move_pos <= b[`FWC_POS_HI:`FWC_POS_LO];
				if (b[`FWC_WHEEL_BIT]) begin
					wb_reg <= b;
					move_wheel <= 2'h1;
				end else begin
					wa_reg <= b;
					move_wheel <= 2'h0;
				end
			end
		end
	end

	// =====================================================
	// reply fifo
	fwc_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_data(rep_byte),
		.in_valid(rep_push),
		.in_ready(fifo_in_ready),
		.out_data(reply_data),
		.out_valid(reply_valid),
		.out_ready(reply_ready)
	);
endmodule // fwc_codec

`default_nettype wire

// *** verilog/fwc_codec_regs.vh ***
/*
 byte codes, field positions and reset values for the filter wheel
 command codec. assumes inclusion by its bare name from design files.
*/
// Summary of operation
// - a move byte is wheel*128 + speed*16 + position in one byte.
// - bit 7 of a move byte is 0 for the first or third wheel, 1 for the second.
// - speed runs 0 to 7 and position 0 to 9; positions 10 to 15 are undefined.
// - a prefix byte 252 routes the following move byte (bit 7 clear) to the third wheel.
// - byte 253 starts the controller type and configuration reply.
// - shutter C codes act only when shutter C replaces the third wheel.
// - the conditional open code for shutter C does nothing.
// - a status reply starts by echoing code 204.
// - the second reply byte is the first wheel state with bit 7 clear.
// - the third reply byte is the second wheel state with bit 7 set.
// - the third wheel takes two reply bytes: 252 then its state with bit 7 clear.
// - the next byte is shutter A state, 170 meaning open.
// - shutter A reports 171 when open conditional on first wheel movement.
// - shutter A reports 172 when closed.
// - shutter B follows: 186 open, 187 conditional, 188 closed.
`ifndef FWC_CODEC_REGS_VH
`define FWC_CODEC_REGS_VH

`define FWC_WHEEL_BIT 7
`define FWC_SPEED_HI 6
`define FWC_SPEED_LO 4
`define FWC_POS_HI 3
`define FWC_POS_LO 0
`define FWC_POS_MAX 4'h9
`define FWC_STATE_RESET 8'h00

`define FWC_CODE_STATUS 8'hcc
`define FWC_CODE_RESET 8'hfb
`define FWC_CODE_PREFIX_C 8'hfc
`define FWC_CODE_CONFIG 8'hfd
`define FWC_CODE_SHC_OPEN 8'hea
`define FWC_CODE_SHC_COND 8'heb
`define FWC_CODE_SHC_CLOSE 8'hec

`define FWC_SHA_OPEN 8'haa
`define FWC_SHA_COND 8'hab
`define FWC_SHA_CLOSED 8'hac
`define FWC_SHB_OPEN 8'hba
`define FWC_SHB_COND 8'hbb
`define FWC_SHB_CLOSED 8'hbc

`define FWC_SH_CLOSED 2'h0
`define FWC_SH_OPEN 2'h1
`define FWC_SH_COND 2'h2

`endif

// *** verilog/fwc_fifo.v ***
/*
 synchronous fifo with valid/ready on both sides.
 assumes one clock and an asynchronous active low reset.
*/
`default_nettype none

module fwc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire reset_n,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_reg;
	reg [AW-1:0] rd_reg;
	reg [AW:0] cnt_reg;
	wire do_wr;
	wire do_rd;

	assign in_ready = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_reg];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	always @(posedge clk) begin
		if (do_wr)
			mem[wr_reg] <= in_data;
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (do_wr)
				wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					wr_reg + 1'b1;
			if (do_rd)
				rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					rd_reg + 1'b1;
			if (do_wr && !do_rd)
				cnt_reg <= cnt_reg + 1'b1;
			else if (do_rd && !do_wr)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule // fwc_fifo

`default_nettype wire

// *** dv/fwc_codec_assertions.sv ***
/* checker for fwc_codec, bound to its ports.
 assumes one clock and reset_n active low. */
`default_nettype none
module fwc_codec_assertions (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [7:0] reply_data,
	input wire logic reply_valid,
	input wire logic shutter_c_enable,
	input wire logic move_valid,
	input wire logic [1:0] move_wheel,
	input wire logic [2:0] move_speed,
	input wire logic [3:0] move_pos,
	input wire logic shutter_c_open,
	input wire logic config_start,
	input wire logic motion_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// sequences and properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// tracks a pending third-wheel prefix seen on the port
	logic prefix_reg;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			prefix_reg <= 1'b0;
		else if (cmd_valid && cmd_ready)
			prefix_reg <= !prefix_reg && cmd_data == 8'hfc;
	end
	sequence s_take(b);
		cmd_valid && cmd_ready && cmd_data == b;
	endsequence
	// after a prefix only a byte with bit 7 clear is a move
	sequence s_move;
		cmd_valid && cmd_ready && cmd_data[3:0] <= 4'h9 &&
			(!prefix_reg || !cmd_data[7]);
	endsequence
	sequence s_echo_out;
		!cmd_ready ##1 reply_valid && reply_data == 8'hcc;
	endsequence
	property p_move;
		s_move |=> move_valid && move_pos == $past(cmd_data[3:0])
			&& move_speed == $past(cmd_data[6:4]);
	endproperty
	property p_wheel_b;
		s_move ##0 cmd_data[7] |=> move_wheel == 2'h1;
	endproperty
	property p_wheel_a;
		s_move ##0 !prefix_reg && !cmd_data[7] |=> move_wheel == 2'h0;
	endproperty
	property p_wheel_c;
		s_move ##0 prefix_reg |=> move_wheel == 2'h2;
	endproperty
	property p_bad_pos;
		cmd_valid && cmd_ready && cmd_data[3:0] > 4'h9 |=> !move_valid;
	endproperty
	property p_config;
		s_take(8'hfd) ##0 !prefix_reg |=> config_start;
	endproperty
	property p_reset;
		s_take(8'hfb) |=> motion_reset;
	endproperty
	// echo reaches the fifo head two cycles after the take
	property p_echo;
		s_take(8'hcc) ##0 !prefix_reg && !reply_valid |=> s_echo_out;
	endproperty
	property p_c_open;
		s_take(8'hea) ##0 !prefix_reg && shutter_c_enable
			|=> shutter_c_open;
	endproperty
	property p_c_off;
		(s_take(8'hea) or s_take(8'hec)) ##0 !shutter_c_enable
			|=> $stable(shutter_c_open);
	endproperty
	property p_c_cond;
		s_take(8'heb) |=> $stable(shutter_c_open);
	endproperty
	a_move: assert property (p_move) else $error("move fields");
	a_wheel_b: assert property (p_wheel_b) else $error("wheel b");
	a_wheel_a: assert property (p_wheel_a) else $error("wheel a");
	a_wheel_c: assert property (p_wheel_c) else $error("wheel c");
	a_bad_pos: assert property (p_bad_pos) else $error("bad pos");
	a_config: assert property (p_config) else $error("config");
	a_reset: assert property (p_reset) else $error("reset");
	a_echo: assert property (p_echo) else $error("echo");
	a_c_open: assert property (p_c_open) else $error("c open");
	a_c_off: assert property (p_c_off) else $error("c off");
	a_c_cond: assert property (p_c_cond) else $error("c cond");
endmodule // fwc_codec_assertions
bind fwc_codec fwc_codec_assertions u_chk (.clk(clk), .reset_n(reset_n),
	.cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
	.reply_data(reply_data), .reply_valid(reply_valid),
	.shutter_c_enable(shutter_c_enable), .move_valid(move_valid),
	.move_wheel(move_wheel), .move_speed(move_speed), .move_pos(move_pos),
	.shutter_c_open(shutter_c_open), .config_start(config_start),
	.motion_reset(motion_reset));
`default_nettype wire

// *** dv/fwc_host_model.sv ***
/* host model: offers command bytes, drains reply bytes.
 assumes callers run 1 ns after a rising edge. */
`default_nettype none
module fwc_host_model (
	input wire logic clk,
	output logic [7:0] cmd_data,
	output logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [7:0] reply_data,
	input wire logic reply_valid,
	output logic reply_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	bit hung;
	initial begin
		cmd_data = 8'h00;
		cmd_valid = 1'b0;
		reply_ready = 1'b0;
		hung = 1'b0;
	end
	// ==========================================
	// byte held until taken
	task automatic send(input logic [7:0] b);
		int i;
		@(posedge clk) #1;
		cmd_data = b;
		cmd_valid = 1'b1;
		for (i = 0; i < 64 && cmd_ready !== 1'b1; i++)
			@(posedge clk) #1;
		hung |= (i == 64);
		@(posedge clk) #1;
		cmd_valid = 1'b0;
		cmd_data = ~b; // idle data must not look valid
	endtask
	task automatic recv(input int n, output logic [7:0] q[$]);
		int i;
		q = {};
		reply_ready = 1'b1;
		repeat (n) begin
			for (i = 0; i < 64 && reply_valid !== 1'b1; i++)
				@(posedge clk) #1;
			hung |= (i == 64);
			q.push_back(reply_data);
			@(posedge clk) #1;
		end
		reply_ready = 1'b0;
	endtask
endmodule // fwc_host_model
`default_nettype wire

// *** dv/testbench.sv ***
/* self-checking bench for fwc_codec.
 assumes the host model drives the command and reply handshakes. */
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	$display("MISMATCH %s exp %h got %h", nm, e, g); mismatches++; end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, shutter_c_enable;
	logic [1:0] shutter_a_state, shutter_b_state;
	wire logic [7:0] cmd_data, reply_data;
	wire logic cmd_valid, cmd_ready, reply_valid, reply_ready, move_valid;
	wire logic [1:0] move_wheel;
	wire logic [2:0] move_speed;
	wire logic [3:0] move_pos;
	wire logic shutter_c_open, config_start, motion_reset;
	int mismatches = 0;
	int n_checks = 0;
	fwc_codec uut (.clk(clk), .reset_n(reset_n), .cmd_data(cmd_data),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.reply_data(reply_data), .reply_valid(reply_valid),
		.reply_ready(reply_ready), .shutter_c_enable(shutter_c_enable),
		.shutter_a_state(shutter_a_state), .shutter_b_state(shutter_b_state),
		.move_valid(move_valid), .move_wheel(move_wheel),
		.move_speed(move_speed), .move_pos(move_pos),
		.shutter_c_open(shutter_c_open), .config_start(config_start),
		.motion_reset(motion_reset));
	fwc_host_model host (.clk(clk), .cmd_data(cmd_data),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.reply_data(reply_data), .reply_valid(reply_valid),
		.reply_ready(reply_ready));
	// ==========================================
	// scenarios
	task automatic t_moves();
		logic [7:0] t[3] = '{8'h79, 8'hf9, 8'h35};
		for (int k = 0; k < 3; k++) begin
			if (k == 2)
				host.send(8'hfc);
			host.send(t[k]);
			`CHK("move_valid", 1'b1, move_valid)
			`CHK("wheel", k[1:0], move_wheel)
			`CHK("speed", t[k][6:4], move_speed)
			`CHK("pos", t[k][3:0], move_pos)
		end
		host.send(8'h7a);
		`CHK("pos10", 1'b0, move_valid)
	endtask
	// three replies overflow 16 words, so the codec must stall
	task automatic t_status();
		logic [7:0] q[$];
		logic [7:0] e[$];
		shutter_a_state = 2'h1;
		shutter_b_state = 2'h2;
		repeat (3) host.send(8'hcc);
		e = '{8'hcc, 8'h79, 8'hf9, 8'hfc, 8'h35, 8'haa, 8'hbb};
		e = {e, e, e};
		host.recv(21, q);
		foreach (e[k]) `CHK("reply", e[k], q[k])
		shutter_c_enable = 1'b1;
		shutter_a_state = 2'h2;
		shutter_b_state = 2'h1;
		host.send(8'hcc);
		e = '{8'hcc, 8'h79, 8'hf9, 8'hab, 8'hba};
		host.recv(5, q);
		foreach (e[k]) `CHK("reply_c", e[k], q[k])
		shutter_c_enable = 1'b0;
		shutter_a_state = 2'h0;
		shutter_b_state = 2'h3;
		host.send(8'hcc);
		e = '{8'hcc, 8'h79, 8'hf9, 8'hfc, 8'h35, 8'hac, 8'hbc};
		host.recv(7, q);
		foreach (e[k]) `CHK("reply_cl", e[k], q[k])
		shutter_a_state = 2'h1;
		shutter_b_state = 2'h2;
		host.send(8'hcc);
		e = '{8'hcc, 8'h79, 8'hf9, 8'hfc, 8'h35, 8'haa, 8'hbb};
		host.recv(7, q);
		foreach (e[k]) `CHK("reply_op", e[k], q[k])
	endtask
	task automatic t_special();
		host.send(8'hfd);
		`CHK("config", 1'b1, config_start)
		host.send(8'hfc);
		host.send(8'hfb);
		`CHK("reset", 1'b1, motion_reset)
		host.send(8'h12);
		`CHK("after_reset", 2'h0, move_wheel)
		host.send(8'hfc);
		host.send(8'h0c);
		host.send(8'h13);
		`CHK("drop_prefix", 2'h0, move_wheel)
		shutter_c_enable = 1'b1;
		host.send(8'hea);
		`CHK("c_open", 1'b1, shutter_c_open)
		shutter_c_enable = 1'b0;
		host.send(8'hec);
		`CHK("c_off", 1'b1, shutter_c_open)
		shutter_c_enable = 1'b1;
		host.send(8'hec);
		`CHK("c_close", 1'b0, shutter_c_open)
		host.send(8'heb);
		`CHK("c_cond", 1'b0, shutter_c_open)
		shutter_c_enable = 1'b0;
		host.send(8'hea);
		`CHK("c_off_open", 1'b0, shutter_c_open)
	endtask
	task automatic finish_test();
		if (host.hung)
			mismatches++;
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		reset_n = 1'b0;
		shutter_c_enable = 1'b0;
		shutter_a_state = 2'h0;
		shutter_b_state = 2'h0;
		repeat (16) @(posedge clk);
		#1 reset_n = 1'b1;
		`CHK("ready", 1'b1, cmd_ready)
		t_moves();
		t_status();
		t_special();
		finish_test();
	end
	initial begin
		#100000;
		mismatches++;
		finish_test();
	end
endmodule // testbench
`default_nettype wire
